// ### hw/bbx_exec.sv
`timescale 1ns/10ps
module bbx_exec
  import bbx_pkg::*;
#(
  parameter int DEPTH = REG_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // program fetch
  input wire logic [INSTR_W-1:0] fetch_word,
  output logic [PC_W-1:0] fetch_addr,
  // core state
  input wire logic [DATA_W-1:0] wreg,
  input wire logic [PLH_W-1:0] pc_high_latch,
  // return stack
  output logic stack_push,
  output logic [PC_W-1:0] return_stack_top,
  // execution status
  output logic slot_discard
);
  bbx_mem_if memif ();

  bbx_regfile #(
    .DEPTH(DEPTH)
  ) u_regfile (
    .clk(clk),
    .rst_n(rst_n),
    .port(memif.mem)
  );

  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] pc_d;
  logic [INSTR_W-1:0] ir_q;
  logic [INSTR_W-1:0] ir_d;
  logic push_q;
  logic push_d;
  logic [PC_W-1:0] tos_q;
  logic [PC_W-1:0] tos_d;
  logic disc_q;
  logic disc_d;
  bbx_op_t op;
  logic [DATA_W-1:0] mask;
  logic bit_val;
  logic [PC_W-1:0] bra_off;
  logic [PC_W-1:0] call_tgt;

  // decode of the executing word
  always_comb begin
    op = OP_NONE;
    if (ir_q[INSTR_W-1 -: 2] == BITOP_CLASS) begin
      case (ir_q[INSTR_W-3 -: 2])
        BITOP_CLR: op = OP_BCLR;
        BITOP_SET: op = OP_BSET;
        BITOP_SKC: op = OP_SKC;
        default: op = OP_SKS;
      endcase
    end else if (ir_q[INSTR_W-1 -: 5] == BRA_CODE) begin
      op = OP_BRA;
    end else if (ir_q[INSTR_W-1 -: 3] == CALL_CODE) begin
      op = OP_CALL;
    end else if (ir_q == BRW_WORD) begin
      op = OP_BRW;
    end
  end

  always_comb begin
    mask = DATA_W'(1) << ir_q[B_MSB:B_LSB];
    bit_val = |(memif.rdata & mask);
    bra_off = {{(PC_W-BRA_K_W){ir_q[BRA_K_MSB]}}, ir_q[BRA_K_MSB:0]};
    call_tgt = {pc_high_latch[PLH_HI_MSB:PLH_HI_LSB],
                ir_q[CALL_K_MSB:0]};
  end

  // next-state and register file access
  always_comb begin
    pc_d = pc_q + PC_STEP;
    ir_d = fetch_word;
    push_d = 1'b0;
    tos_d = tos_q;
    disc_d = 1'b0;
    memif.raddr = fetch_word[F_MSB:F_LSB];
    memif.waddr = ir_q[F_MSB:F_LSB];
    memif.wdata = memif.rdata;
    memif.we = 1'b0;
    case (op)
      OP_BCLR: begin
        memif.we = 1'b1;
        memif.wdata = memif.rdata & ~mask;
      end
      OP_BSET: begin
        memif.we = 1'b1;
        memif.wdata = memif.rdata | mask;
      end
      OP_SKC: begin
        if (!bit_val) begin
          ir_d = NOP_WORD;
          disc_d = 1'b1;
        end
      end
      OP_SKS: begin
        if (bit_val) begin
          ir_d = NOP_WORD;
          disc_d = 1'b1;
        end
      end
      OP_BRA: begin
        pc_d = pc_q + bra_off;
        ir_d = NOP_WORD;
        disc_d = 1'b1;
      end
      OP_BRW: begin
        pc_d = pc_q + PC_W'(wreg);
        ir_d = NOP_WORD;
        disc_d = 1'b1;
      end
      OP_CALL: begin
        push_d = 1'b1;
        tos_d = pc_q;
        pc_d = call_tgt;
        ir_d = NOP_WORD;
        disc_d = 1'b1;
      end
      default: begin
        pc_d = pc_q + PC_STEP;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_q <= PC_RESET;
      ir_q <= NOP_WORD;
      push_q <= 1'b0;
      tos_q <= PC_RESET;
      disc_q <= 1'b0;
    end else begin
      pc_q <= pc_d;
      ir_q <= ir_d;
      push_q <= push_d;
      tos_q <= tos_d;
      disc_q <= disc_d;
    end
  end

  assign fetch_addr = pc_q;
  assign stack_push = push_q;
  assign return_stack_top = tos_q;
  assign slot_discard = disc_q;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_clear_bit: assert property (
    op == OP_BCLR |-> memif.we && (memif.wdata & mask) == '0 &&
      (memif.wdata | mask) == (memif.rdata | mask))
    else $error("bit clear wrote wrong value");
  chk_set_bit: assert property (
    op == OP_BSET |-> memif.we && (memif.wdata & mask) == mask &&
      (memif.wdata & ~mask) == (memif.rdata & ~mask))
    else $error("bit set wrote wrong value");
  chk_bra_target: assert property (
    op == OP_BRA |=> fetch_addr == PC_W'($past(pc_q) + $past(bra_off)))
    else $error("literal branch target wrong");
  chk_bra_flush: assert property (
    op == OP_BRA |=> slot_discard && op == OP_NONE ##1 !slot_discard)
    else $error("literal branch did not discard one slot");
  chk_brw_target: assert property (
    op == OP_BRW |=> fetch_addr == PC_W'($past(pc_q) + PC_W'($past(wreg))))
    else $error("register branch target wrong");
  chk_brw_refill: assert property (
    op == OP_BRW |=> slot_discard && !memif.we &&
      fetch_addr == $past(pc_d))
    else $error("register branch refill wrong");
  chk_skip_clear: assert property (
    op == OP_SKC |=> slot_discard == !$past(bit_val))
    else $error("skip-if-clear decision wrong");
  chk_skip_set: assert property (
    op == OP_SKS |=> slot_discard == $past(bit_val))
    else $error("skip-if-set decision wrong");
  chk_call_push: assert property (
    op == OP_CALL |=> stack_push && return_stack_top == $past(pc_q))
    else $error("call pushed wrong return address");
  chk_call_low: assert property (
    op == OP_CALL |=>
      fetch_addr[CALL_K_MSB:0] == $past(ir_q[CALL_K_MSB:0]))
    else $error("call low target bits wrong");
  chk_call_high: assert property (
    op == OP_CALL |=> fetch_addr[PC_W-1:CALL_K_W] ==
      $past(pc_high_latch[PLH_HI_MSB:PLH_HI_LSB]))
    else $error("call high target bits wrong");
  chk_call_cycles: assert property (
    op == OP_CALL |=> slot_discard && stack_push ##1 !stack_push)
    else $error("call did not take two cycles");
  chk_pc_wrap: assert property (
    op == OP_NONE && !disc_q |=> fetch_addr == PC_W'($past(pc_q) + 1))
    else $error("sequential fetch did not advance");

  cov_bra: cover property (op == OP_BRA ##2 op != OP_NONE);
  cov_call: cover property (op == OP_CALL ##1 stack_push);
  cov_skip: cover property (op == OP_SKS ##1 slot_discard);
  cov_rmw: cover property (op == OP_BSET ##1 op == OP_SKC);
endmodule

// ### hw/bbx_regfile.sv
`timescale 1ns/10ps
module bbx_regfile
  import bbx_pkg::*;
#(
  parameter int DEPTH = REG_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // access port
  bbx_mem_if.mem port
);
  logic [DATA_W-1:0] mem_q [DEPTH];
  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] rdata_q;

  // write-first forwarding on a same-address collision
  always_comb begin
    rdata_d = mem_q[port.raddr];
    if (port.we && port.waddr == port.raddr) begin
      rdata_d = port.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (port.we) begin
      mem_q[port.waddr] <= port.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign port.rdata = rdata_q;
endmodule

// ### shared/bbx_mem_if.sv
`timescale 1ns/10ps
interface bbx_mem_if;
  import bbx_pkg::*;
  logic [FADDR_W-1:0] raddr;
  logic [FADDR_W-1:0] waddr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic we;
  modport ctrl (output raddr, output waddr, output wdata, output we,
                input rdata);
  modport mem (input raddr, input waddr, input wdata, input we,
               output rdata);
endinterface

// ### shared/bbx_pkg.sv
package bbx_pkg;
  // widths
  localparam int PC_W = 15;
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int REG_DEPTH = 128;
  // instruction fields
  localparam int F_LSB = 0;
  localparam int F_MSB = 6;
  localparam int B_LSB = 7;
  localparam int B_MSB = 9;
  localparam int BRA_K_MSB = 8;
  localparam int BRA_K_W = 9;
  localparam int CALL_K_MSB = 10;
  localparam int CALL_K_W = 11;
  localparam int PLH_W = 7;
  localparam int PLH_HI_MSB = 6;
  localparam int PLH_HI_LSB = 3;
  // encodings
  localparam logic [1:0] BITOP_CLASS = 2'h1;
  localparam logic [1:0] BITOP_CLR = 2'h0;
  localparam logic [1:0] BITOP_SET = 2'h1;
  localparam logic [1:0] BITOP_SKC = 2'h2;
  localparam logic [1:0] BITOP_SKS = 2'h3;
  localparam logic [4:0] BRA_CODE = 5'h19;
  localparam logic [2:0] CALL_CODE = 3'h4;
  localparam logic [INSTR_W-1:0] BRW_WORD = 14'h000b;
  localparam logic [INSTR_W-1:0] NOP_WORD = 14'h0000;
  // reset value and sequential step
  localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
  localparam logic [PC_W-1:0] PC_STEP = 15'h0001;

  typedef enum logic [2:0] {
    OP_NONE, OP_BCLR, OP_BSET, OP_SKC, OP_SKS, OP_BRA, OP_BRW, OP_CALL
  } bbx_op_t;
endpackage

// ### test/bbx_prog_mem.sv
`timescale 1ns/10ps
module bbx_prog_mem
  import bbx_pkg::*;
(
  // fetch port
  input wire logic [PC_W-1:0] addr,
  output logic [INSTR_W-1:0] word
);
  // program store, loaded by the bench
  logic [INSTR_W-1:0] mem [0:(1<<PC_W)-1];

  // combinational read, same cycle as address
  assign word = mem[addr];
endmodule

// ### test/bit_op_branch_call_exec_tb.sv
`timescale 1ns/10ps
module bit_op_branch_call_exec_tb
  import bbx_pkg::*;
;
  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic psh;
    logic [PC_W-1:0] tp;
  } bbx_note_t;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [DATA_W-1:0] wreg = 8'h00;
  logic [PLH_W-1:0] plh = 7'h00;
  logic [INSTR_W-1:0] fetch_word;
  logic [PC_W-1:0] fetch_addr;
  logic [PC_W-1:0] stk_top;
  logic push;
  logic discard;
  int bad_count = 0;
  int checks = 0;
  logic [15:0] seed = 16'h323e;
  bbx_note_t notes[$];
  bbx_note_t n;

  initial begin
    forever #50 clk = ~clk;
  end

  bbx_exec #(.DEPTH(REG_DEPTH)) u_dut (.clk(clk), .rst_n(rst_n),
    .fetch_word(fetch_word), .fetch_addr(fetch_addr), .wreg(wreg),
    .pc_high_latch(plh), .stack_push(push), .return_stack_top(stk_top),
    .slot_discard(discard));
  bbx_prog_mem u_mem (.addr(fetch_addr), .word(fetch_word));

  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction

  task automatic check(input string what, input logic [PC_W-1:0] seen,
                       input logic [PC_W-1:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (bad_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // monitor: every redirect or discard slot consumes one note
  always @(negedge clk) begin
    if (rst_n && (discard | push) !== 1'b0) begin
      if (notes.size() == 0) begin
        check("extra slot", 15'h0001, 15'h0000);
      end else begin
        n = notes.pop_front();
        check("fetch_addr", fetch_addr, n.pc);
        check("slot_discard", {14'h0000, discard}, 15'h0001);
        check("stack_push", {14'h0000, push}, {14'h0000, n.psh});
        check("return_stack_top", stk_top, n.tp);
      end
    end
  end

  task automatic run_round();
    logic [PC_W-1:0] t1, t2, t3;
    logic [8:0] k9;
    logic [10:0] k11;
    logic [DATA_W-1:0] w;
    logic [PLH_W-1:0] p;
    logic [6:0] f;
    logic [2:0] b;
    logic [17:0] ops;
    logic [INSTR_W-1:0] cw;
    int i;
    rst_n <= 1'b0;
    f = 7'(rnd());
    b = 3'(rnd());
    k9 = 9'(rnd());
    k11 = 11'(rnd());
    w = 8'(rnd());
    p = 7'(rnd());
    cw = {CALL_CODE, 11'h7ff};
    t1 = 15'h000a + {{6{k9[8]}}, k9};
    if (t1 < 15'h0010 || t1 >= 15'h7ff0) begin
      k9[8] = ~k9[8];
      t1 = 15'h000a + {{6{k9[8]}}, k9};
    end
    t2 = t1 + 15'h0001 + {7'h00, w};
    if (t2 < 15'h0010) begin
      w = 8'h00;
      t2 = t1 + 15'h0001;
    end
    t3 = {p[6:3], k11};
    for (i = 0; i < 8; i++) begin
      if (t3 < 15'h0010 || t3 == t1 || t3 == t2) begin
        k11 = k11 + 11'h020;
        t3 = {p[6:3], k11};
      end
    end
    for (i = 0; i < (1 << PC_W); i++) begin
      u_mem.mem[i] = NOP_WORD;
    end
    u_mem.mem[t2 + 15'h0001] = cw;
    u_mem.mem[t1 + 15'h0001] = cw;
    u_mem.mem[t3] = NOP_WORD;
    u_mem.mem[t2] = {CALL_CODE, k11};
    u_mem.mem[t1] = BRW_WORD;
    ops = {BITOP_SET, BITOP_SKS, BITOP_CLR, BITOP_CLR, BITOP_SKC, BITOP_CLR,
           BITOP_SKS, BITOP_SET, BITOP_SKC};
    for (i = 0; i < 9; i++) begin
      u_mem.mem[i] = {BITOP_CLASS, ops[17 - 2 * i -: 2], b, f};
    end
    u_mem.mem[2] = cw;
    u_mem.mem[5] = cw;
    u_mem.mem[9] = {BRA_CODE, k9};
    u_mem.mem[10] = cw;
    notes.push_back({15'h0003, 1'b0, 15'h0000});
    notes.push_back({15'h0006, 1'b0, 15'h0000});
    notes.push_back({t1, 1'b0, 15'h0000});
    notes.push_back({t2, 1'b0, 15'h0000});
    notes.push_back({t3, 1'b1, t2 + 15'h0001});
    wreg <= w;
    plh <= p;
    repeat (10) @(negedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 40 && notes.size() > 0; i++) begin
      @(negedge clk);
    end
    if (notes.size() != 0) begin
      check("pending slots", 15'(notes.size()), 15'h0000);
      end_of_test();
    end
    repeat (4) @(negedge clk);
  endtask

  initial begin
    repeat (3) run_round();
    end_of_test();
  end
endmodule
